// [common/cupw_params.svh]
// Purpose: Constants of the capture-unit PWM block
// Assumes: Included by bare name after the package
// Notes: Offsets are byte addresses on the register port
// Function
// - Sync pulse loads counter with phase preload
// - Phase preload rewritable; sync uses current value
// - Counter advances one per system clock
// - Carrier equals clock over period count
// - Polarity selects active high or low
// - Sync output feeds next unit's input
// - Pass-through mode forwards incoming sync pulse
// - Match mode pulses when counter increment reaches period
`ifndef CUPW_PARAMS_SVH
`define CUPW_PARAMS_SVH
// ----------------------------------------
// Register port
// ----------------------------------------
`define CUPW_ADDR_W 8
`define CUPW_DATA_W 32
`define CUPW_OFF_CTRL 8'h00
`define CUPW_OFF_PERIOD 8'h04
`define CUPW_OFF_COMPARE 8'h08
`define CUPW_OFF_PHASE 8'h0C
`define CUPW_OFF_COUNT 8'h10
`define CUPW_OFF_STATUS 8'h14
// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define CUPW_CTRL_W 3
`define CUPW_CTRL_EN 0
`define CUPW_CTRL_POL 1
`define CUPW_CTRL_SYNC 2
`define CUPW_STAT_SYNC 0
`define CUPW_STAT_RUN 1
`define CUPW_RST_CTRL 3'h0
`define CUPW_RST_PERIOD 32'h0000_2710
`define CUPW_RST_COMPARE 32'h0000_0000
`define CUPW_RST_PHASE 32'h0000_0000
`endif

// [common/cupw_pkg.sv]
// Purpose: Types of the capture-unit PWM block
// Assumes: Compiled before all design files
// Notes: Enumerations carry no explicit codes
`default_nettype none
package cupw_pkg;
  // Source of the outgoing chain pulse
  typedef enum logic {CUPW_SYNC_PASS, CUPW_SYNC_MATCH} cupw_sync_sel_t;
  // Level of the active part of the waveform
  typedef enum logic {CUPW_POL_HIGH, CUPW_POL_LOW} cupw_pol_t;
endpackage
`default_nettype wire

// [rtl/cupw_counter.sv]
// Purpose: Period counter with phase load and restart
// Assumes: Sync load comes from logic on sys_clk
// Notes: Terminal cycle is the one whose increment reaches period
`timescale 1ns/1ps
`default_nettype none
module cupw_counter #(
  parameter int CNT_W = 16 // Counter width
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic run,
  input wire logic sync_load,
  input wire logic [CNT_W-1:0] phase_preload,
  input wire logic [CNT_W-1:0] period_value,
  output logic [CNT_W-1:0] count,
  output logic period_match
);
  // Count state
  logic [CNT_W-1:0] count_reg, count_next;
  // Helper for the carrier check
  logic [CNT_W:0] gap_reg;
  logic clean_reg;

  // Increment, shared by match detect and next value
  function automatic logic [CNT_W-1:0] inc(input logic [CNT_W-1:0] v);
    return CNT_W'(v + 1'b1);
  endfunction

  // ----------------------------------------
  // Next count
  // ----------------------------------------
  always_comb begin
    period_match = run && (inc(count_reg) == period_value);
    if (!run) begin
      count_next = '0;
    end else if (sync_load) begin
      count_next = phase_preload;
    end else if (period_match) begin
      count_next = '0;
    end else begin
      count_next = inc(count_reg);
    end
  end

  // Register the count
  always_ff @(posedge sys_clk) begin
    if (!nrst) count_reg <= '0;
    else count_reg <= count_next;
  end

  assign count = count_reg;

  // Cycles since the last match, for the carrier check
  always_ff @(posedge sys_clk) begin
    if (!nrst || !run) begin
      gap_reg <= '0;
      clean_reg <= 1'b0;
    end else if (period_match) begin
      gap_reg <= (CNT_W+1)'(1);
      // A pulse in the match cycle loads the phase, so the next period is not whole
      clean_reg <= !sync_load;
    end else begin
      gap_reg <= (CNT_W+1)'(gap_reg + 1'b1);
      if (sync_load || !$stable(period_value)) clean_reg <= 1'b0;
    end
  end

  step_one_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    run && !sync_load && !period_match |=> count_reg == CNT_W'($past(count_reg) + 1'b1))
    else $error("counter did not advance by one");
  restart_zero_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    run && !sync_load && period_match |=> count_reg == '0)
    else $error("counter did not restart at zero");
  carrier_len_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    period_match && clean_reg && $stable(period_value) |-> CNT_W'(gap_reg) == period_value)
    else $error("carrier period differs from period value");
endmodule
`default_nettype wire

// [rtl/cupw_sync_out.sv]
// Purpose: Outgoing chain pulse selection
// Assumes: Inputs are on sys_clk
// Notes: Pulse leaves one cycle after its cause
`timescale 1ns/1ps
`default_nettype none
module cupw_sync_out (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire cupw_pkg::cupw_sync_sel_t sync_sel,
  input wire logic sync_in,
  input wire logic period_match,
  output logic sync_out
);
  // Registered chain pulse
  logic sync_out_reg, sync_out_next;

  // ----------------------------------------
  // Select the pulse source
  // ----------------------------------------
  always_comb begin
    case (sync_sel)
      cupw_pkg::CUPW_SYNC_PASS: sync_out_next = sync_in;
      cupw_pkg::CUPW_SYNC_MATCH: sync_out_next = period_match;
      default: sync_out_next = 1'b0;
    endcase
  end

  // Register toward the next unit
  always_ff @(posedge sys_clk) begin
    if (!nrst) sync_out_reg <= 1'b0;
    else sync_out_reg <= sync_out_next;
  end

  assign sync_out = sync_out_reg;

  pass_fwd_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    sync_sel == cupw_pkg::CUPW_SYNC_PASS |=> sync_out_reg == $past(sync_in))
    else $error("sync pulse not passed through");
  match_fwd_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    sync_sel == cupw_pkg::CUPW_SYNC_MATCH |=> sync_out_reg == $past(period_match))
    else $error("sync output does not follow period match");
  chain_cause_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    sync_out_reg |-> $past(sync_in) || $past(period_match))
    else $error("sync output without a cause");
endmodule
`default_nettype wire

// [rtl/cupw_top.sv]
// Purpose: Capture unit run as a single-output PWM generator
// Assumes: sync_in is a one-cycle pulse from a unit on sys_clk
// Notes: Registers sit on a plain strobe port, reads return next cycle
//
// The strobed register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "cupw_params.svh"
module cupw_top #(
  parameter int CNT_W = 16 // Counter, period, compare and phase width
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [`CUPW_ADDR_W-1:0] reg_addr,
  input wire logic [`CUPW_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [`CUPW_DATA_W-1:0] reg_rdata,
  input wire logic sync_in,
  output logic sync_out,
  output logic pwm_out
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------

  // Control: enable, polarity, sync source
  logic [`CUPW_CTRL_W-1:0] ctrl_reg, ctrl_next;
  // Period value, end of one carrier cycle
  logic [CNT_W-1:0] period_reg, period_next;
  // Compare value, end of the active part
  logic [CNT_W-1:0] compare_reg, compare_next;
  // Phase preload, copied in on sync
  logic [CNT_W-1:0] phase_reg, phase_next;
  // Sticky flag: a sync pulse arrived
  logic sync_seen_reg, sync_seen_next;
  // Read data, valid one cycle after the strobe
  logic [`CUPW_DATA_W-1:0] rdata_reg, rdata_next;
  // Waveform output flop
  logic pwm_reg, pwm_next;

  // Live counter value
  logic [CNT_W-1:0] cnt_val;
  // Counter is in its terminal cycle
  logic period_match;
  // Block enabled
  logic run;
  // Decoded polarity
  cupw_pkg::cupw_pol_t pol;
  // Decoded sync-out source
  cupw_pkg::cupw_sync_sel_t sync_sel;
  // Counter inside the active part
  logic active;

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------

  // True when a write strobe hits the given offset
  function automatic logic wr_hit(
    input logic wr,
    input logic [`CUPW_ADDR_W-1:0] a,
    input logic [`CUPW_ADDR_W-1:0] off
  );
    return wr && (a == off);
  endfunction

  // Zero-extend a counter-wide value to a bus word
  function automatic logic [`CUPW_DATA_W-1:0] to_word(
    input logic [CNT_W-1:0] v
  );
    return `CUPW_DATA_W'(v);
  endfunction

  // ----------------------------------------
  // Control decode
  // ----------------------------------------

  // Field views of the control register
  assign run = ctrl_reg[`CUPW_CTRL_EN];
  assign pol = cupw_pkg::cupw_pol_t'(ctrl_reg[`CUPW_CTRL_POL]);
  assign sync_sel = cupw_pkg::cupw_sync_sel_t'(ctrl_reg[`CUPW_CTRL_SYNC]);

  // ----------------------------------------
  // Register writes
  // ----------------------------------------

  // Next values of the software registers
  always_comb begin
    ctrl_next = ctrl_reg;
    period_next = period_reg;
    compare_next = compare_reg;
    phase_next = phase_reg;
    sync_seen_next = sync_seen_reg;
    // Control word
    if (wr_hit(reg_wr, reg_addr, `CUPW_OFF_CTRL)) begin
      ctrl_next = reg_wdata[`CUPW_CTRL_W-1:0];
    end
    // Period may change while running, takes effect at once
    if (wr_hit(reg_wr, reg_addr, `CUPW_OFF_PERIOD)) begin
      period_next = reg_wdata[CNT_W-1:0];
    end
    // Compare value sets the active width
    if (wr_hit(reg_wr, reg_addr, `CUPW_OFF_COMPARE)) begin
      compare_next = reg_wdata[CNT_W-1:0];
    end
    // Phase may be rewritten at any time
    if (wr_hit(reg_wr, reg_addr, `CUPW_OFF_PHASE)) begin
      phase_next = reg_wdata[CNT_W-1:0];
    end
    // Write one clears the sticky sync flag
    if (wr_hit(reg_wr, reg_addr, `CUPW_OFF_STATUS)) begin
      if (reg_wdata[`CUPW_STAT_SYNC]) begin
        sync_seen_next = 1'b0;
      end
    end
    // A new pulse wins over a clear in the same cycle
    if (sync_in) begin
      sync_seen_next = 1'b1;
    end
  end

  // Register the software state
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      ctrl_reg <= `CUPW_RST_CTRL;
      period_reg <= CNT_W'(`CUPW_RST_PERIOD);
      compare_reg <= CNT_W'(`CUPW_RST_COMPARE);
      phase_reg <= CNT_W'(`CUPW_RST_PHASE);
      sync_seen_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      period_reg <= period_next;
      compare_reg <= compare_next;
      phase_reg <= phase_next;
      sync_seen_reg <= sync_seen_next;
    end
  end

  // ----------------------------------------
  // Register reads
  // ----------------------------------------

  // Read data for one cycle only, zero otherwise
  always_comb begin
    rdata_next = '0;
    if (reg_rd) begin
      case (reg_addr)
        `CUPW_OFF_CTRL: rdata_next = `CUPW_DATA_W'(ctrl_reg);
        `CUPW_OFF_PERIOD: rdata_next = to_word(period_reg);
        `CUPW_OFF_COMPARE: rdata_next = to_word(compare_reg);
        `CUPW_OFF_PHASE: rdata_next = to_word(phase_reg);
        // Live count shows the block's own state
        `CUPW_OFF_COUNT: rdata_next = to_word(cnt_val);
        `CUPW_OFF_STATUS: begin
          rdata_next[`CUPW_STAT_SYNC] = sync_seen_reg;
          rdata_next[`CUPW_STAT_RUN] = run;
        end
        // Unmapped offsets read as zero
        default: rdata_next = '0;
      endcase
    end
  end

  // Register the read data
  always_ff @(posedge sys_clk) begin
    if (!nrst) rdata_reg <= '0;
    else rdata_reg <= rdata_next;
  end

  assign reg_rdata = rdata_reg;

  // ----------------------------------------
  // Counter
  // ----------------------------------------

  // Period counter; sync loads the phase only while running
  cupw_counter #(
    .CNT_W(CNT_W)
  ) u_counter (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .run(run),
    .sync_load(sync_in),
    .phase_preload(phase_reg),
    .period_value(period_reg),
    .count(cnt_val),
    .period_match(period_match)
  );

  // ----------------------------------------
  // Chain output
  // ----------------------------------------

  // Pass-through or period-match pulse to the next unit
  cupw_sync_out u_sync_out (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .sync_sel(sync_sel),
    .sync_in(sync_in),
    .period_match(period_match),
    .sync_out(sync_out)
  );

  // ----------------------------------------
  // Waveform
  // ----------------------------------------

  // Active while the count is below the compare value
  always_comb begin
    active = run && (cnt_val < compare_reg);
    // Polarity turns the active part high or low
    if (pol == cupw_pkg::CUPW_POL_LOW) begin
      pwm_next = !active;
    end else begin
      pwm_next = active;
    end
  end

  // Register the output pin level
  always_ff @(posedge sys_clk) begin
    if (!nrst) pwm_reg <= 1'b0;
    else pwm_reg <= pwm_next;
  end

  assign pwm_out = pwm_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------

  // Sync taken while running
  sequence s_sync_taken;
    run && sync_in;
  endsequence

  // Counter holds the phase present at the pulse
  sequence s_phase_loaded;
    cnt_val == $past(phase_reg);
  endsequence

  // Phase write without sync, away from the terminal cycle
  sequence s_phase_write_only;
    run && !sync_in && !period_match &&
      wr_hit(reg_wr, reg_addr, `CUPW_OFF_PHASE);
  endsequence

  phase_load_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_sync_taken |=> s_phase_loaded)
    else $error("counter not loaded with phase on sync");

  phase_live_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_phase_write_only |=> cnt_val == CNT_W'($past(cnt_val) + 1'b1)
      ##0 phase_reg == $past(reg_wdata[CNT_W-1:0]))
    else $error("phase write disturbed the count");

  pol_idle_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    !run && $stable(ctrl_reg) |=> pwm_out == $past(ctrl_reg[`CUPW_CTRL_POL]))
    else $error("idle output not at inactive level");

  pol_active_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    run && (cnt_val < compare_reg) |=> pwm_out != $past(ctrl_reg[`CUPW_CTRL_POL]))
    else $error("active part at wrong level");

  sync_sticky_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    sync_in |=> sync_seen_reg)
    else $error("sync flag lost");

  read_once_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    !reg_rd |=> reg_rdata == '0)
    else $error("read data outside its cycle");

  // Disabled counter sits at zero, a pulse loads nothing
  idle_count_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    !run |=> cnt_val == '0)
    else $error("disabled counter not at zero");

  // Pass-through pulse reaches the chain pin next cycle
  pass_pin_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    sync_sel == cupw_pkg::CUPW_SYNC_PASS && sync_in |=> sync_out)
    else $error("chain pin missed a passed pulse");

  // Match pulse reaches the chain pin next cycle
  match_pin_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    sync_sel == cupw_pkg::CUPW_SYNC_MATCH && period_match |=> sync_out)
    else $error("chain pin missed a match pulse");

  // No stray chain pulse in match mode
  match_quiet_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    sync_sel == cupw_pkg::CUPW_SYNC_MATCH && !period_match |=> !sync_out)
    else $error("chain pin pulsed without a match");

  // Write one clears the flag when no pulse competes
  flag_clear_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    wr_hit(reg_wr, reg_addr, `CUPW_OFF_STATUS) && reg_wdata[`CUPW_STAT_SYNC] && !sync_in |=> !sync_seen_reg)
    else $error("sync flag not cleared");

  // Count read returns the value at the strobe
  count_read_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    reg_rd && reg_addr == `CUPW_OFF_COUNT |=> reg_rdata == to_word($past(cnt_val)))
    else $error("count read differs from live count");

  // Period read returns the stored period
  period_read_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    reg_rd && reg_addr == `CUPW_OFF_PERIOD |=> reg_rdata == to_word($past(period_reg)))
    else $error("period read differs from stored period");

endmodule
`default_nettype wire

// [test/cupw_load_model.sv]
// Purpose: Meter on the waveform pin, as an external load would see it
// Assumes: Waveform is registered on sys_clk
// Notes: Reports cycles between rising edges and high cycles per period
`timescale 1ns/1ps
`default_nettype none
module cupw_load_model (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic clr,
  input wire logic pwm_in,
  output logic [15:0] seen_period,
  output logic [15:0] seen_high,
  output logic seen_valid
);
  logic [15:0] run_reg; // Cycles since last rising edge
  logic [15:0] hi_reg; // High cycles since last rising edge
  logic last_reg; // Previous pin level
  logic [1:0] edges_reg; // Rising edges seen since clear
  // A rising edge closes one carrier period
  always @(posedge sys_clk) begin
    if (!nrst || clr) begin
      run_reg <= 16'h0;
      hi_reg <= 16'h0;
      last_reg <= 1'b0;
      edges_reg <= 2'h0;
      seen_period <= 16'h0;
      seen_high <= 16'h0;
      seen_valid <= 1'b0;
    end else begin
      last_reg <= pwm_in;
      if (pwm_in && !last_reg) begin
        seen_period <= run_reg;
        seen_high <= hi_reg;
        run_reg <= 16'h1;
        hi_reg <= 16'h1;
        if (edges_reg != 2'h2) begin
          edges_reg <= edges_reg + 2'h1;
        end
        // Only the span between two true edges counts; the first may be a false edge after clear
        seen_valid <= (edges_reg == 2'h2);
      end else begin
        run_reg <= run_reg + 16'h1;
        hi_reg <= hi_reg + {15'h0, pwm_in};
      end
    end
  end
endmodule
`default_nettype wire

// [test/test_capture_unit_aux_pwm.sv]
// Purpose: Self-checking bench of the capture-unit PWM block
// Assumes: Register port answers one cycle after a read strobe
// Notes: A cycle model is compared with every output on every edge
`timescale 1ns/1ps
`default_nettype none
`include "cupw_params.svh"
module test_capture_unit_aux_pwm;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic sync_in = 1'b0;
  logic clr = 1'b0;
  wire logic [31:0] reg_rdata;
  wire logic sync_out;
  wire logic pwm_out;
  wire logic [15:0] s_per;
  wire logic [15:0] s_hi;
  wire logic s_ok;
  int bad_count = 0;
  int total_checks = 0;
  int seed = 32'hE9BB272A;
  int i;
  logic [31:0] r;
  // Model state
  logic en, pol, sel, flag;
  logic [15:0] per, cmp, ph, cnt;
  logic x_sync, x_pwm;
  logic [31:0] x_rd;

  always #10 sys_clk = ~sys_clk;

  cupw_top #(.CNT_W(16)) DUT (.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sync_in(sync_in), .sync_out(sync_out),
    .pwm_out(pwm_out));
  cupw_load_model LOAD (.sys_clk(sys_clk), .nrst(nrst), .clr(clr), .pwm_in(pwm_out), .seen_period(s_per),
    .seen_high(s_hi), .seen_valid(s_ok));

  // ----------------------------------------
  // Shared helpers
  // ----------------------------------------
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One bus access, optionally with a chain pulse in the same cycle
  task automatic acc(logic w, logic [7:0] a, logic [31:0] d, logic s);
    @(posedge sys_clk);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    sync_in <= s;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    sync_in <= 1'b0;
  endtask

  // Clear the meter, wait for three rising edges, compare period and high time
  task automatic measure(logic [15:0] pe, logic [15:0] he);
    @(posedge sys_clk);
    clr <= 1'b1;
    @(posedge sys_clk);
    clr <= 1'b0;
    for (int k = 0; k < 300; k++) begin
      @(posedge sys_clk);
      #1;
      if (s_ok) break;
    end
    if (!s_ok) begin
      bad_count++;
      $display("Error meter timeout expected 1 seen 0");
      tally_and_finish;
    end else begin
      check("carrier period", {16'h0, pe}, {16'h0, s_per});
      check("high time", {16'h0, he}, {16'h0, s_hi});
    end
  endtask

  function automatic logic [31:0] rmux(logic [7:0] a);
    case (a)
      `CUPW_OFF_CTRL: rmux = {29'h0, sel, pol, en};
      `CUPW_OFF_PERIOD: rmux = {16'h0, per};
      `CUPW_OFF_COMPARE: rmux = {16'h0, cmp};
      `CUPW_OFF_PHASE: rmux = {16'h0, ph};
      `CUPW_OFF_COUNT: rmux = {16'h0, cnt};
      `CUPW_OFF_STATUS: rmux = {30'h0, en, flag};
      default: rmux = 32'h0;
    endcase
  endfunction

  // Cycle model, compared just after each edge
  always @(posedge sys_clk) begin : model
    logic hit;
    hit = en && (cnt + 16'h1 == per);
    x_sync = sel ? hit : sync_in;
    x_pwm = en ? ((cnt < cmp) ^ pol) : pol;
    x_rd = reg_rd ? rmux(reg_addr) : 32'h0;
    if (!en) cnt = 16'h0;
    else if (sync_in) cnt = ph;
    else if (hit) cnt = 16'h0;
    else cnt = cnt + 16'h1;
    if (sync_in) flag = 1'b1;
    else if (reg_wr && reg_addr == `CUPW_OFF_STATUS && reg_wdata[0]) flag = 1'b0;
    if (reg_wr) begin
      case (reg_addr)
        `CUPW_OFF_CTRL: {sel, pol, en} = reg_wdata[2:0];
        `CUPW_OFF_PERIOD: per = reg_wdata[15:0];
        `CUPW_OFF_COMPARE: cmp = reg_wdata[15:0];
        `CUPW_OFF_PHASE: ph = reg_wdata[15:0];
        default: ;
      endcase
    end
    if (!nrst) begin
      {en, pol, sel, flag} = 4'h0;
      per = 16'h2710;
      {cmp, ph, cnt} = 48'h0;
      {x_sync, x_pwm, x_rd} = 34'h0;
    end
    #1;
    check("pwm_out", {31'h0, x_pwm}, {31'h0, pwm_out});
    check("sync_out", {31'h0, x_sync}, {31'h0, sync_out});
    check("reg_rdata", x_rd, reg_rdata);
  end

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (50000) @(posedge sys_clk);
    bad_count++;
    tally_and_finish;
  end

  initial begin
    repeat (12) @(posedge sys_clk);
    nrst <= 1'b1;
    // Reset values, unmapped read, read-only write
    for (i = 0; i < 7; i++) acc(1'b0, 8'(i * 4), 32'h0, 1'b0);
    acc(1'b0, 8'h40, 32'h0, 1'b0);
    acc(1'b1, `CUPW_OFF_COUNT, 32'h1234, 1'b0);
    // Carrier period and duty, both polarities
    acc(1'b1, `CUPW_OFF_PERIOD, 32'h5, 1'b0);
    acc(1'b1, `CUPW_OFF_COMPARE, 32'h2, 1'b0);
    acc(1'b1, `CUPW_OFF_CTRL, 32'h1, 1'b0);
    measure(16'h5, 16'h2);
    acc(1'b1, `CUPW_OFF_CTRL, 32'h3, 1'b0);
    measure(16'h5, 16'h3);
    acc(1'b1, `CUPW_OFF_PERIOD, 32'h1, 1'b0);
    acc(1'b0, `CUPW_OFF_COUNT, 32'h0, 1'b0);
    // Pass-through chain and phase load
    acc(1'b1, `CUPW_OFF_PERIOD, 32'h28, 1'b0);
    acc(1'b1, `CUPW_OFF_CTRL, 32'h1, 1'b0);
    acc(1'b1, `CUPW_OFF_PHASE, 32'h11, 1'b0);
    acc(1'b1, 8'hFC, 32'h0, 1'b1);
    acc(1'b0, `CUPW_OFF_COUNT, 32'h0, 1'b0);
    acc(1'b1, `CUPW_OFF_PHASE, 32'h21, 1'b1);
    acc(1'b0, `CUPW_OFF_COUNT, 32'h0, 1'b1);
    acc(1'b0, `CUPW_OFF_STATUS, 32'h0, 1'b0);
    acc(1'b1, `CUPW_OFF_STATUS, 32'h1, 1'b1);
    acc(1'b1, `CUPW_OFF_STATUS, 32'h1, 1'b0);
    acc(1'b0, `CUPW_OFF_STATUS, 32'h0, 1'b0);
    // Pulse while disabled
    acc(1'b1, `CUPW_OFF_CTRL, 32'h0, 1'b0);
    acc(1'b1, 8'hFC, 32'h0, 1'b1);
    // Period-match chain source
    acc(1'b1, `CUPW_OFF_CTRL, 32'h5, 1'b0);
    repeat (100) @(posedge sys_clk);
    acc(1'b1, `CUPW_OFF_PHASE, 32'h26, 1'b0);
    acc(1'b1, 8'hFC, 32'h0, 1'b1);
    // Second reset in mid-run
    nrst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    nrst <= 1'b1;
    // Random traffic
    for (i = 0; i < 1500; i++) begin
      r = $random(seed);
      case (r[2:0])
        3'h0: acc(1'b1, `CUPW_OFF_CTRL, {29'h0, r[5:3]}, r[6]);
        3'h1: acc(1'b1, `CUPW_OFF_PERIOD, {27'h0, r[12:8]} + 32'h1, r[6]);
        3'h2: acc(1'b1, `CUPW_OFF_COMPARE, {26'h0, r[13:8]}, r[6]);
        3'h3: acc(1'b1, `CUPW_OFF_PHASE, 32'(r[15:0] % per), r[6]);
        3'h4: acc(1'b0, {1'b0, r[12:8], 2'b00}, 32'h0, r[6]);
        3'h5: acc(1'b1, `CUPW_OFF_STATUS, {31'h0, r[8]}, r[6]);
        default: acc(1'b1, 8'hFC, 32'h0, r[6]);
      endcase
    end
    tally_and_finish;
  end
endmodule
`default_nettype wire
